// ===== logic/timer_counter_regs.svh
// register offsets, field positions and reset values of the timer block
`ifndef TIMER_COUNTER_REGS_SVH
`define TIMER_COUNTER_REGS_SVH

`define OFF_CCR      6'h00
`define OFF_CMR      6'h04
`define OFF_CV       6'h10
`define OFF_RA       6'h14
`define OFF_RB       6'h18
`define OFF_RC       6'h1c
`define OFF_SR       6'h20
`define ADDR_BCR     8'hc0
`define ADDR_BMR     8'hc4

`define CCR_CLK_ON   0
`define CCR_CLK_OFF  1
`define CCR_SOFT_TRG 2
`define BCR_SYNC     0

`define CMR_CLKSEL   0
`define CMR_CLKINV   3
`define CMR_BURST    4
`define CMR_HALT     6
`define CMR_DISABLE  7
`define CMR_TRGEDGE  8
`define CMR_TRGSEL   10
`define CMR_EVSRC    10
`define CMR_EVTRGEN  12
`define CMR_SHAPE    13
`define CMR_WAVE     15
`define CMR_RCTRGEN  16
`define CMR_RA_CAPTURE_EDGE     17
`define CMR_RB_CAPTURE_EDGE     19
`define CMR_ACT_RA   17
`define CMR_ACT_RCA  19
`define CMR_ACT_EVA  21
`define CMR_ACT_SWA  23
`define CMR_ACT_RB   25
`define CMR_ACT_RCB  27
`define CMR_ACT_EVB  29

`define SR_OVF       0
`define SR_OVR       1
`define SR_RA_CAPTURE_EDGE      2
`define SR_RB_CAPTURE_EDGE      3
`define SR_RCMATCH   4
`define SR_CLKRUN    16
`define SR_LINE_A    17
`define SR_LINE_B    18

`define REG_RESET    32'h0000_0000
`define COUNT_TOP    16'hffff

`endif

// ===== logic/timer_pkg.sv
// types shared by the timer block
package timer_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] cmr;
    logic [15:0] ra;
    logic [15:0] rb;
    logic [15:0] rc;
    logic [15:0] cnt;
    logic        en;
    logic        stopped;
    logic        pend;
    logic        dir;
    logic        step;
    logic        a_taken;
    logic        ra_unread;
    logic        rb_unread;
    logic        ovf;
    logic        ovr;
    logic        ra_capture_edge;
    logic        rb_capture_edge;
    logic        rcm;
    logic        a;
    logic        b;
    logic        a_oe;
    logic        b_oe;
  } ch_type;

  typedef struct packed {
    logic       slow;
    logic [2:0] b;
    logic [2:0] a;
    logic [2:0] ext;
  } pins_type;

  typedef struct packed {
    ch_type [2:0] ch;
    logic [5:0]   bmr;
    pins_type     s1;
    pins_type     s2;
    pins_type     s3;
    logic [2:0]   xc_prev;
    logic [6:0]   pre;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
  } state_type;
endpackage

// ===== logic/three_channel_timer_counter.sv
// three 16-bit timer/counter channels with an APB register slave
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "timer_counter_regs.svh"
module three_channel_timer_counter (
  input  logic                  REF_CLK_IN,
  input  logic                  RESET_IN,
  input  timer_pkg::apb_req_type APB_REQ_IN,
  output logic [31:0]           PRDATA_OUT,
  output logic                  PREADY_OUT,
  output logic                  PSLVERR_OUT,
  input  logic                  SLOW_CLK_IN,
  input  logic [2:0]            EXT_CLK_IN,
  input  logic [2:0]            IO_A_IN,
  input  logic [2:0]            IO_B_IN,
  output logic [2:0]            IO_A_OUT,
  output logic [2:0]            IO_A_OE_OUT,
  output logic [2:0]            IO_B_OUT,
  output logic [2:0]            IO_B_OE_OUT
);
  import timer_pkg::*;

  state_type   st_q;
  state_type   st_d;
  ch_type      c;
  ch_type      n;
  logic [31:0] m;
  logic [4:0]  tap;
  logic [2:0]  xc;
  logic [2:0]  line_a;
  logic        wr;
  logic        rd;
  logic        setup;
  logic        chw;
  logic        chr;
  logic        sync;
  logic        wave;
  logic        updown;
  logic [2:0]  sel;
  logic [1:0]  bsel;
  logic [1:0]  evsrc;
  logic        raw;
  logic        tick;
  logic        sw;
  logic        ev;
  logic        trig;
  logic        ra_m;
  logic        rb_m;
  logic        rc_m;
  logic        lda;
  logic        ldb;
  logic        halt_ev;
  logic        dis_ev;
  logic        d;
  logic [15:0] top;

  // rising, falling or both (code 0 = never)
  function automatic logic edge_hit(input logic [1:0] mode, input logic cur,
                                    input logic prev);
    return (mode[0] & cur & ~prev) | (mode[1] & ~cur & prev);
  endfunction

  // 0 keep, 1 set, 2 clear, 3 toggle
  function automatic logic act(input logic [1:0] a, input logic v);
    case (a)
      2'h1:    return 1'b1;
      2'h2:    return 1'b0;
      2'h3:    return ~v;
      default: return v;
    endcase
  endfunction

  // chain clock mux: pin, none, or line A of one of the other two channels
  function automatic logic xc_pick(input int i, input logic [1:0] s,
                                   input logic pin, input logic [2:0] la);
    case (s)
      2'h0:    return pin;
      2'h2:    return la[(i == 0) ? 1 : 0];
      2'h3:    return la[(i == 2) ? 1 : 2];
      default: return 1'b0;
    endcase
  endfunction

  always_comb begin
    st_d    = st_q;
    c       = st_q.ch[0];
    n       = c;
    m       = c.cmr;
    wave    = 1'b0;
    updown  = 1'b0;
    sel     = 3'h0;
    bsel    = 2'h0;
    evsrc   = 2'h0;
    raw     = 1'b0;
    tick    = 1'b0;
    sw      = 1'b0;
    ev      = 1'b0;
    trig    = 1'b0;
    ra_m    = 1'b0;
    rb_m    = 1'b0;
    rc_m    = 1'b0;
    lda     = 1'b0;
    ldb     = 1'b0;
    halt_ev = 1'b0;
    dis_ev  = 1'b0;
    d       = 1'b0;
    top     = `COUNT_TOP;
    chw     = 1'b0;
    chr     = 1'b0;
    setup   = APB_REQ_IN.psel & APB_REQ_IN.penable & ~st_q.pready;
    wr      = APB_REQ_IN.psel & APB_REQ_IN.penable & st_q.pready & APB_REQ_IN.pwrite;
    rd      = APB_REQ_IN.psel & APB_REQ_IN.penable & st_q.pready & ~APB_REQ_IN.pwrite;
    sync    = wr & (APB_REQ_IN.paddr == `ADDR_BCR) & APB_REQ_IN.pwdata[`BCR_SYNC];

    // first stage feeds only the second
    st_d.s1 = {SLOW_CLK_IN, IO_B_IN, IO_A_IN, EXT_CLK_IN};
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.pre = st_q.pre + 7'h01;
    tap = {st_q.s2.slow & ~st_q.s3.slow, &st_q.pre[6:0], &st_q.pre[4:0],
           &st_q.pre[2:0], st_q.pre[0]};

    for (int i = 0; i < 3; i++) begin
      line_a[i] = st_q.ch[i].cmr[`CMR_WAVE] ? st_q.ch[i].a : st_q.s2.a[i];
    end
    for (int i = 0; i < 3; i++) begin
      xc[i] = xc_pick(i, st_q.bmr[2*i +: 2], st_q.s2.ext[i], line_a);
    end
    st_d.xc_prev = xc;

    if (wr & (APB_REQ_IN.paddr == `ADDR_BMR)) begin
      st_d.bmr = APB_REQ_IN.pwdata[5:0];
    end

    for (int i = 0; i < 3; i++) begin
      c      = st_q.ch[i];
      n      = c;
      m      = c.cmr;
      wave   = m[`CMR_WAVE];
      updown = wave & m[`CMR_SHAPE];
      top    = (wave & m[`CMR_SHAPE+1]) ? c.rc : `COUNT_TOP;
      chw    = wr & (APB_REQ_IN.paddr[7:6] == 2'(i));
      chr    = rd & (APB_REQ_IN.paddr[7:6] == 2'(i));

      // software access; clears come first so that events below win
      if (chw & (APB_REQ_IN.paddr[5:0] == `OFF_CMR)) n.cmr = APB_REQ_IN.pwdata;
      if (chw & (APB_REQ_IN.paddr[5:0] == `OFF_RC))  n.rc  = APB_REQ_IN.pwdata[15:0];
      if (chw & wave & (APB_REQ_IN.paddr[5:0] == `OFF_RA)) n.ra = APB_REQ_IN.pwdata[15:0];
      if (chw & wave & (APB_REQ_IN.paddr[5:0] == `OFF_RB)) n.rb = APB_REQ_IN.pwdata[15:0];
      if (chr & (APB_REQ_IN.paddr[5:0] == `OFF_RA)) n.ra_unread = 1'b0;
      if (chr & (APB_REQ_IN.paddr[5:0] == `OFF_RB)) n.rb_unread = 1'b0;
      if (chr & (APB_REQ_IN.paddr[5:0] == `OFF_SR)) begin
        n.ovf  = 1'b0;
        n.ovr  = 1'b0;
        n.ra_capture_edge = 1'b0;
        n.rb_capture_edge = 1'b0;
        n.rcm  = 1'b0;
      end
      sw = (chw & (APB_REQ_IN.paddr[5:0] == `OFF_CCR) & APB_REQ_IN.pwdata[`CCR_SOFT_TRG])
           | sync;

      // counter clock: tap or chain clock edge, then burst gate
      sel  = m[`CMR_CLKSEL +: 3];
      bsel = m[`CMR_BURST +: 2];
      if (sel < 3'h5) begin
        raw = tap[sel];
      end else begin
        raw = edge_hit(m[`CMR_CLKINV] ? 2'h2 : 2'h1, xc[2'(sel - 3'h5)],
                       st_q.xc_prev[2'(sel - 3'h5)]);
      end
      tick = raw & ((bsel == 2'h0) | xc[2'(bsel - 2'h1)]) & c.en & ~c.stopped;

      // compares look at the value settled one cycle after each step
      ra_m = c.step & (c.cnt == c.ra);
      rb_m = c.step & (c.cnt == c.rb);
      rc_m = c.step & (c.cnt == c.rc);
      if (rc_m) n.rcm = 1'b1;

      // external trigger or event
      evsrc = m[`CMR_EVSRC +: 2];
      if (!wave) begin
        ev = m[`CMR_TRGSEL] ?
             edge_hit(m[`CMR_TRGEDGE +: 2], st_q.s2.b[i], st_q.s3.b[i]) :
             edge_hit(m[`CMR_TRGEDGE +: 2], st_q.s2.a[i], st_q.s3.a[i]);
      end else if (evsrc == 2'h0) begin
        ev = edge_hit(m[`CMR_TRGEDGE +: 2], st_q.s2.b[i], st_q.s3.b[i]);
      end else begin
        ev = edge_hit(m[`CMR_TRGEDGE +: 2], xc[2'(evsrc - 2'h1)],
                      st_q.xc_prev[2'(evsrc - 2'h1)]);
      end
      // RC trigger: capture by enable bit, waveform only in shape 10
      trig = sw | (ev & (~wave | m[`CMR_EVTRGEN]))
             | (rc_m & (wave ? (m[`CMR_SHAPE +: 2] == 2'b10) : m[`CMR_RCTRGEN]));

      // capture loads, RA and RB alternate after each trigger
      lda = ~wave & ~c.a_taken
            & edge_hit(m[`CMR_RA_CAPTURE_EDGE +: 2], st_q.s2.a[i], st_q.s3.a[i]);
      ldb = ~wave & c.a_taken
            & edge_hit(m[`CMR_RB_CAPTURE_EDGE +: 2], st_q.s2.a[i], st_q.s3.a[i]);
      if (lda) begin
        n.ra        = c.cnt;
        n.a_taken   = 1'b1;
        n.ra_capture_edge      = 1'b1;
        n.ra_unread = 1'b1;
        if (c.ra_unread) n.ovr = 1'b1;
      end
      if (ldb) begin
        n.rb        = c.cnt;
        n.a_taken   = 1'b0;
        n.rb_capture_edge      = 1'b1;
        n.rb_unread = 1'b1;
        if (c.rb_unread) n.ovr = 1'b1;
      end
      if (trig) n.a_taken = 1'b0;

      // enable / start control
      halt_ev = m[`CMR_HALT] & ((~wave & ldb) | (wave & rc_m));
      dis_ev  = m[`CMR_DISABLE] & ((~wave & ldb) | (wave & rc_m));
      if ((chw & (APB_REQ_IN.paddr[5:0] == `OFF_CCR) & APB_REQ_IN.pwdata[`CCR_CLK_OFF])
          | dis_ev) begin
        n.en = 1'b0;
      end else if (chw & (APB_REQ_IN.paddr[5:0] == `OFF_CCR)
                   & APB_REQ_IN.pwdata[`CCR_CLK_ON]) begin
        n.en      = 1'b1;
        n.stopped = c.en ? c.stopped : 1'b0;
      end
      if (c.en) begin
        if (halt_ev) n.stopped = 1'b1;
        // a match that halts must not be undone by its own shape-10 restart
        if (trig & ~(halt_ev & wave)) n.stopped = 1'b0;
      end

      // a trigger waits for the next counter clock edge
      n.pend = trig | (c.pend & ~tick);
      n.step = tick;
      if (tick) begin
        d = (c.pend & updown) ? ~c.dir : c.dir;
        if (c.pend & ~updown) begin
          n.cnt = 16'h0000;
        end else if (updown) begin
          if (!d) begin
            if (c.cnt >= top) begin
              d     = 1'b1;
              n.cnt = c.cnt - 16'h0001;
            end else begin
              n.cnt = c.cnt + 16'h0001;
            end
          end else if (c.cnt == 16'h0000) begin
            d     = 1'b0;
            n.cnt = 16'h0001;
          end else begin
            n.cnt = c.cnt - 16'h0001;
          end
        end else begin
          n.cnt = c.cnt + 16'h0001;
          if (c.cnt == `COUNT_TOP) n.ovf = 1'b1;
        end
        n.dir = d;
      end

      // waveform outputs, software trigger has the last word
      n.a_oe = wave;
      n.b_oe = wave & (evsrc != 2'h0);
      if (wave) begin
        if (ra_m) n.a = act(m[`CMR_ACT_RA +: 2], n.a);
        if (rc_m) n.a = act(m[`CMR_ACT_RCA +: 2], n.a);
        if (ev)   n.a = act(m[`CMR_ACT_EVA +: 2], n.a);
        if (sw)   n.a = act(m[`CMR_ACT_SWA +: 2], n.a);
        if (evsrc != 2'h0) begin
          if (rb_m) n.b = act(m[`CMR_ACT_RB +: 2], n.b);
          if (rc_m) n.b = act(m[`CMR_ACT_RCB +: 2], n.b);
          if (ev)   n.b = act(m[`CMR_ACT_EVB +: 2], n.b);
          if (sw)   n.b = act(m[31:30], n.b);
        end
      end
      st_d.ch[i] = n;
    end

    // one wait state: data and error are latched in the first access cycle
    st_d.pready  = setup;
    st_d.pslverr = 1'b0;
    if (setup) begin
      st_d.prdata = `REG_RESET;
      c = st_q.ch[APB_REQ_IN.paddr[7:6]];
      if (APB_REQ_IN.paddr[7:6] == 2'h3) begin
        if (APB_REQ_IN.paddr == `ADDR_BMR) st_d.prdata = {26'h0, st_q.bmr};
        else if (APB_REQ_IN.paddr != `ADDR_BCR) st_d.pslverr = 1'b1;
      end else begin
        case (APB_REQ_IN.paddr[5:0])
          `OFF_CCR: st_d.prdata = `REG_RESET;
          `OFF_CMR: st_d.prdata = c.cmr;
          `OFF_CV:  st_d.prdata = {16'h0, c.cnt};
          `OFF_RA:  st_d.prdata = {16'h0, c.ra};
          `OFF_RB:  st_d.prdata = {16'h0, c.rb};
          `OFF_RC:  st_d.prdata = {16'h0, c.rc};
          `OFF_SR: begin
            st_d.prdata[`SR_OVF]     = c.ovf;
            st_d.prdata[`SR_OVR]     = c.ovr;
            st_d.prdata[`SR_RA_CAPTURE_EDGE]    = c.ra_capture_edge;
            st_d.prdata[`SR_RB_CAPTURE_EDGE]    = c.rb_capture_edge;
            st_d.prdata[`SR_RCMATCH] = c.rcm;
            st_d.prdata[`SR_CLKRUN]  = c.en;
            st_d.prdata[`SR_LINE_A]  = line_a[APB_REQ_IN.paddr[7:6]];
            st_d.prdata[`SR_LINE_B]  = c.cmr[`CMR_WAVE] & (c.cmr[`CMR_EVSRC +: 2] != 2'h0) ?
                                       c.b : st_q.s2.b[APB_REQ_IN.paddr[7:6]];
          end
          default: st_d.pslverr = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (RESET_IN) begin
      st_q        <= '0;
      st_q.prdata <= `REG_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign PRDATA_OUT  = st_q.prdata;
  assign PREADY_OUT  = st_q.pready;
  assign PSLVERR_OUT = st_q.pslverr;
  for (genvar g = 0; g < 3; g++) begin : g_pins
    assign IO_A_OUT[g]    = st_q.ch[g].a;
    assign IO_A_OE_OUT[g] = st_q.ch[g].a_oe;
    assign IO_B_OUT[g]    = st_q.ch[g].b;
    assign IO_B_OE_OUT[g] = st_q.ch[g].b_oe;
  end
endmodule

// ===== dv/timer_port_checker_assertions.sv
// port-level assertions for the three-channel timer block
`timescale 1ns/1ps
module timer_port_checker (
  input logic                   REF_CLK_IN,
  input logic                   RESET_IN,
  input timer_pkg::apb_req_type APB_REQ_IN,
  input logic                   PREADY_OUT,
  input logic                   PSLVERR_OUT,
  input logic [2:0]             IO_A_OUT,
  input logic [2:0]             IO_A_OE_OUT,
  input logic [2:0]             IO_B_OE_OUT
);
  import timer_pkg::*;
  logic bad_addr;
  logic wr_done;
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RESET_IN);
  sequence s_setup; APB_REQ_IN.psel && !APB_REQ_IN.penable; endsequence
  sequence s_access; APB_REQ_IN.psel && APB_REQ_IN.penable; endsequence
  // the top slot holds only the two block registers
  always_comb bad_addr = (APB_REQ_IN.paddr[7:6] == 2'h3) ? (APB_REQ_IN.paddr[5:0] >= 6'h08) :
    (APB_REQ_IN.paddr[5:0] inside {6'h08, 6'h0c} || APB_REQ_IN.paddr[5:0] >= 6'h24);
  assign wr_done = PREADY_OUT && APB_REQ_IN.pwrite;

  a_one_wait_state: assert property (s_setup ##1 s_access |-> !PREADY_OUT ##1 PREADY_OUT)
    else $error("ready not on second access cycle");
  a_ready_single: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held longer than one cycle");
  a_ready_in_access: assert property (PREADY_OUT |-> s_access)
    else $error("ready outside an access phase");
  a_err_unmapped: assert property (PREADY_OUT && bad_addr |-> PSLVERR_OUT)
    else $error("unmapped access not refused");
  a_err_only_hole: assert property (PSLVERR_OUT |-> PREADY_OUT && bad_addr)
    else $error("error on a mapped access");
  a_b_needs_a: assert property ((IO_B_OE_OUT & ~IO_A_OE_OUT) == 3'h0)
    else $error("line b driven while line a is not");
  a_oe_after_write: assert property ($changed({IO_A_OE_OUT, IO_B_OE_OUT}) |->
    $past(wr_done) || $past(wr_done, 2))
    else $error("line direction changed without a mode write");
  a_reset_quiet: assert property ($fell(RESET_IN) |-> !PREADY_OUT && IO_A_OUT == 3'h0 &&
    IO_A_OE_OUT == 3'h0 && IO_B_OE_OUT == 3'h0)
    else $error("outputs active right after reset");
endmodule

bind three_channel_timer_counter timer_port_checker i_chk (
  .REF_CLK_IN (REF_CLK_IN),
  .RESET_IN   (RESET_IN),
  .APB_REQ_IN (APB_REQ_IN),
  .PREADY_OUT (PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT),
  .IO_A_OUT   (IO_A_OUT),
  .IO_A_OE_OUT(IO_A_OE_OUT),
  .IO_B_OE_OUT(IO_B_OE_OUT)
);

// ===== dv/pin_side_model.sv
// far-side pin model: external clock pins of the three channels
`timescale 1ns/1ps
module pin_side_model (
  input  logic       clk_in,
  output logic [2:0] ext_clk_out
);
  initial ext_clk_out = 3'h0;
  // one period per call, four master cycles per level; idle low between calls
  task automatic tick(input logic [2:0] m);
    repeat (4) @(posedge clk_in);
    ext_clk_out <= m;
    repeat (4) @(posedge clk_in);
    ext_clk_out <= 3'h0;
  endtask
endmodule

// ===== dv/three_channel_timer_counter_tb.sv
// self-checking bench for the three-channel timer block
`timescale 1ns/1ps
`include "timer_counter_regs.svh"
module three_channel_timer_counter_tb;
  import timer_pkg::*;
  logic        clk;
  logic        rst;
  apb_req_type req;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  ext_clk;
  logic [2:0]  a_in;
  logic [2:0]  a_out;
  logic [2:0]  b_in;
  logic [2:0]  b_out;
  logic [2:0]  a_oe;
  logic [2:0]  b_oe;
  int          miscompares;
  int          cmp_count;
  int          cycles;
  int          cnt [3];
  bit          run [3];
  bit          trg [3];
  logic [31:0] lfsr_q = 32'h0f34b47b;
  logic [31:0] mdl [256] = '{default: 32'h0};
  logic [5:0]  offs [6] = '{`OFF_CMR, `OFF_CV, `OFF_RA, `OFF_RB, `OFF_RC, `OFF_SR};

  three_channel_timer_counter i_dut (.REF_CLK_IN(clk), .RESET_IN(rst), .APB_REQ_IN(req),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SLOW_CLK_IN(1'b0),
    .EXT_CLK_IN(ext_clk), .IO_A_IN(a_in), .IO_B_IN(b_in), .IO_A_OUT(a_out),
    .IO_A_OE_OUT(a_oe), .IO_B_OUT(b_out), .IO_B_OE_OUT(b_oe));
  pin_side_model i_pins (.clk_in(clk), .ext_clk_out(ext_clk));

  initial clk = 1'b0;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      wrap_up();
    end
  end

  function automatic logic [7:0] ad(input logic [1:0] c, input logic [5:0] o);
    return {c, o};
  endfunction
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    // ready, data and error are taken at the rising edge that ends the access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic wm(input logic [7:0] a, input logic [31:0] d);
    mdl[a] = d;
    wr(a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic ee);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q & m, mdl[a] & m);
    chk({31'h0, e}, {31'h0, ee});
  endtask
  task automatic ticks(input int n, input logic [2:0] m);
    repeat (n) begin
      i_pins.tick(m);
      for (int c = 0; c < 3; c++) if (m[c] && run[c]) begin
        cnt[c] = trg[c] ? 0 : cnt[c] + 1;
        trg[c] = 1'b0;
      end
    end
    // outputs launched by the last step settle one edge later
    @(posedge clk);
  endtask
  task automatic line_a(input int c, input logic v);
    @(posedge clk);
    a_in[c] <= v;
    repeat (6) @(posedge clk);
  endtask
  task automatic line_b(input int c, input logic v);
    @(posedge clk);
    b_in[c] <= v;
    repeat (6) @(posedge clk);
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    req = '0;
    rst = 1'b1;
    a_in = 3'h0;
    b_in = 3'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int c = 0; c < 3; c++) begin
      foreach (offs[i]) rd(ad(c, offs[i]), 32'hffff_ffff, 1'b0);
      rd(ad(c, 6'h0c), 32'h0, 1'b1);
      lfsr_q = lfsr_next(lfsr_q);
      mdl[ad(c, `OFF_RC)] = lfsr_q & 32'hffff;
      wr(ad(c, `OFF_RC), lfsr_q);
      rd(ad(c, `OFF_RC), 32'hffff_ffff, 1'b0);
    end
    mdl[`ADDR_BMR] = lfsr_q & 32'h3f;
    wr(`ADDR_BMR, lfsr_q);
    rd(`ADDR_BMR, 32'hffff_ffff, 1'b0);
    wm(`ADDR_BMR, 32'h0);
    rd(8'hc8, 32'h0, 1'b1);
    wr(ad(0, `OFF_CCR), 32'h3);
    rd(ad(0, `OFF_SR), 32'h0001_0000, 1'b0);
    wr(ad(0, `OFF_CCR), 32'h1);
    mdl[ad(0, `OFF_SR)] = 32'h0001_0000;
    rd(ad(0, `OFF_SR), 32'h0001_0000, 1'b0);
    wr(ad(0, `OFF_CCR), 32'h2);
    mdl[ad(0, `OFF_SR)] = 32'h0;
    rd(ad(0, `OFF_SR), 32'h0001_0000, 1'b0);
    // sync start of two channels; the disabled third holds, its reset waits for its first step
    for (int c = 0; c < 3; c++) wm(ad(c, `OFF_CMR), 32'h5 + c);
    wr(ad(0, `OFF_CCR), 32'h1);
    wr(ad(1, `OFF_CCR), 32'h1);
    wr(`ADDR_BCR, 32'h1);
    {run[0], run[1], trg[0], trg[1], trg[2]} = 5'h1f;
    ticks(4, 3'b111);
    wr(ad(2, `OFF_CCR), 32'h1);
    run[2] = 1'b1;
    ticks(2, 3'b111);
    for (int c = 0; c < 3; c++) begin
      mdl[ad(c, `OFF_CV)] = cnt[c];
      rd(ad(c, `OFF_CV), 32'hffff_ffff, 1'b0);
    end
    // waveform, count to compare c, toggle line a, halt then disable on match
    wm(ad(0, `OFF_RC), 32'h3);
    wm(ad(0, `OFF_CMR), 32'h0018_c045);
    wr(ad(0, `OFF_CCR), 32'h5);
    ticks(4, 3'b001);
    chk({29'h0, a_out[0], a_oe[0], b_oe[0]}, 32'h6);
    ticks(4, 3'b001);
    chk({31'h0, a_out[0]}, 32'h1);
    mdl[ad(0, `OFF_SR)] = 32'h0001_0010;
    rd(ad(0, `OFF_SR), 32'h0001_0010, 1'b0);
    wm(ad(0, `OFF_CMR), 32'h0018_c085);
    wr(ad(0, `OFF_CCR), 32'h4);
    ticks(4, 3'b001);
    chk({31'h0, a_out[0]}, 32'h0);
    mdl[ad(0, `OFF_SR)] = 32'h0000_0010;
    rd(ad(0, `OFF_SR), 32'h0001_0010, 1'b0);
    // capture on channel 1: ra on rise, rb on fall, second ra overruns
    wm(ad(1, `OFF_CMR), 32'h0012_0006);
    wr(ad(1, `OFF_CCR), 32'h5);
    trg[1] = 1'b1;
    ticks(3, 3'b010);
    line_a(1, 1'b1);
    mdl[ad(1, `OFF_RA)] = cnt[1];
    ticks(2, 3'b010);
    line_a(1, 1'b0);
    mdl[ad(1, `OFF_RB)] = cnt[1];
    ticks(1, 3'b010);
    line_a(1, 1'b1);
    mdl[ad(1, `OFF_RA)] = cnt[1];
    mdl[ad(1, `OFF_SR)] = 32'h0002_000e;
    rd(ad(1, `OFF_SR), 32'h0002_000e, 1'b0);
    rd(ad(1, `OFF_RA), 32'hffff_ffff, 1'b0);
    rd(ad(1, `OFF_RB), 32'hffff_ffff, 1'b0);
    chk({30'h0, a_oe[1], b_oe[1]}, 32'h0);
    // channel 2: capture trigger on a rising line b edge
    wm(ad(2, `OFF_CMR), 32'h0000_0507);
    line_b(2, 1'b1);
    trg[2] = 1'b1;
    ticks(2, 3'b100);
    mdl[ad(2, `OFF_CV)] = cnt[2];
    rd(ad(2, `OFF_CV), 32'hffff_ffff, 1'b0);
    // channel 2: up-down to compare c = 2 starting from 1, rb = 1 toggles line b
    wm(ad(2, `OFF_CMR), 32'h0600_e407);
    wm(ad(2, `OFF_RB), 32'h1);
    wm(ad(2, `OFF_RC), 32'h2);
    ticks(3, 3'b100);
    mdl[ad(2, `OFF_CV)] = 32'h0;
    rd(ad(2, `OFF_CV), 32'hffff_ffff, 1'b0);
    chk({30'h0, b_out[2], b_oe[2]}, 32'h3);
    ticks(1, 3'b100);
    mdl[ad(2, `OFF_CV)] = 32'h1;
    rd(ad(2, `OFF_CV), 32'hffff_ffff, 1'b0);
    chk({31'h0, b_out[2]}, 32'h0);
    wrap_up();
  end
endmodule
